// file: i2c_irq_pkg.sv
package i2c_irq_pkg;

  // ==========================================================================
  // Register offsets (word offsets)
  localparam logic [5:0] OFF_OWN_ADDR   = 6'h00;
  localparam logic [5:0] OFF_ENABLE     = 6'h01;
  localparam logic [5:0] OFF_STATUS     = 6'h02;
  localparam logic [5:0] OFF_CLK_LOW    = 6'h03;
  localparam logic [5:0] OFF_CLK_HIGH   = 6'h04;
  localparam logic [5:0] OFF_COUNT      = 6'h05;
  localparam logic [5:0] OFF_RX_DATA    = 6'h06;
  localparam logic [5:0] OFF_TARGET     = 6'h07;
  localparam logic [5:0] OFF_TX_DATA    = 6'h08;
  localparam logic [5:0] OFF_MODE       = 6'h09;
  localparam logic [5:0] OFF_SOURCE     = 6'h0A;
  localparam logic [5:0] OFF_EXT_MODE   = 6'h0B;
  localparam logic [5:0] OFF_PRESCALE   = 6'h0C;
  localparam logic [5:0] OFF_TX_FIFO    = 6'h20;
  localparam logic [5:0] OFF_RX_FIFO    = 6'h21;

  // ==========================================================================
  // Event bit positions (enable and status share them)
  localparam int EV_ARB_LOST  = 0;
  localparam int EV_NO_ACK    = 1;
  localparam int EV_ACC_READY = 2;
  localparam int EV_RX_READY  = 3;
  localparam int EV_TX_READY  = 4;
  localparam int EV_STOP      = 5;
  localparam int EV_ADDRESSED = 6;
  localparam int EVENT_COUNT  = 7;

  // ==========================================================================
  // Field positions
  localparam int MODE_RESET_BIT   = 5;
  localparam int FIFO_FLAG_BIT    = 7;
  localparam int FIFO_CLEAR_BIT   = 6;
  localparam int FIFO_ENABLE_BIT  = 5;
  localparam int FIFO_LEVEL_LSB   = 0;
  localparam int FIFO_LEVEL_W     = 3;
  localparam int STATUS_TX_EMPTY  = 10;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] STATUS_RESET = 16'h0410;
  localparam logic [15:0] ZERO_RESET   = 16'h0000;
  localparam logic [2:0]  FIFO_MAX     = 3'h4;

endpackage : i2c_irq_pkg

// file: i2c_priority_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_priority_arbiter #(
  parameter int WIDTH = 7
) (
  input  wire logic [WIDTH-1:0] pending,
  output logic      [2:0]       code
);

  // ==========================================================================
  // Lowest index wins; code is index plus one, zero when idle
  always_comb
  begin
    code = 3'h0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        code = 3'(i + 1);
      end
    end
  end

endmodule : i2c_priority_arbiter
`default_nettype wire

// file: i2c_fifo_level_counter.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_fifo_level_counter (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       byteDone,
  input  wire logic [2:0] threshold,
  output logic      [2:0] level,
  output logic            reached
);

  typedef struct packed {
    logic [2:0] count;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ==========================================================================
  // Counts bytes moved, saturating at the largest threshold
  always_comb
  begin
    state_next = state_reg;
    if (clear)
    begin
      state_next.count = 3'h0;
    end
    else if (byteDone && state_reg.count != i2c_irq_pkg::FIFO_MAX)
    begin
      state_next.count = state_reg.count + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level   = state_reg.count;
  // Zero threshold never fires, avoiding a storm at idle
  assign reached = (threshold != 3'h0) && (state_reg.count >= threshold);

endmodule : i2c_fifo_level_counter
`default_nettype wire

// file: i2c_interrupt_reset.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_reset (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  input  wire logic        txLoaded,
  input  wire logic        rxCopied,
  input  wire logic        accessDone,
  input  wire logic        noAck,
  input  wire logic        arbLost,
  input  wire logic        stopSeen,
  input  wire logic        addressed,
  input  wire logic        txFifoByte,
  input  wire logic        rxFifoByte,
  input  wire logic        sdaIn,
  input  wire logic        sclIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             sclOut,
  output logic             sclOe,
  output logic             moduleEnabled,
  output logic             basicEventInterrupt,
  output logic             fifoLevelInterrupt
);

  localparam int NEV = i2c_irq_pkg::EVENT_COUNT;

  typedef struct packed {
    logic [15:0]    ownAddr;
    logic [NEV-1:0] enable;
    logic [NEV-1:0] flags;
    logic           txEmpty;
    logic [15:0]    clkLow;
    logic [15:0]    clkHigh;
    logic [15:0]    count;
    logic [15:0]    rxData;
    logic [15:0]    target;
    logic [15:0]    txData;
    logic [15:0]    mode;
    logic [2:0]     source;
    logic [15:0]    extMode;
    logic [15:0]    prescale;
    logic           txFifoOn;
    logic [2:0]     txThresh;
    logic           txFifoFlag;
    logic           rxFifoOn;
    logic [2:0]     rxThresh;
    logic           rxFifoFlag;
    logic [15:0]    rdData;
    logic           basicIrq;
    logic           fifoIrq;
    logic           enabledOut;
    logic [2:0]     sdaSync;
    logic [2:0]     sclSync;
    logic           sdaLevel;
    logic           sclLevel;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [NEV-1:0] events;
  logic [NEV-1:0] pending;
  logic [2:0]     nextCode;
  logic [2:0]     txLevel;
  logic [2:0]     rxLevel;
  logic           txReached;
  logic           rxReached;
  logic           inReset;
  logic           txClear;
  logic           rxClear;

  // ==========================================================================
  // Event collection
  assign events[i2c_irq_pkg::EV_ARB_LOST]  = arbLost;
  assign events[i2c_irq_pkg::EV_NO_ACK]    = noAck;
  assign events[i2c_irq_pkg::EV_ACC_READY] = accessDone;
  assign events[i2c_irq_pkg::EV_RX_READY]  = rxCopied;
  assign events[i2c_irq_pkg::EV_TX_READY]  = txLoaded;
  assign events[i2c_irq_pkg::EV_STOP]      = stopSeen;
  assign events[i2c_irq_pkg::EV_ADDRESSED] = addressed;

  assign inReset = !state_reg.mode[i2c_irq_pkg::MODE_RESET_BIT];
  // Gating by enable; flags themselves stay visible for polling
  assign pending = state_reg.flags & state_reg.enable;

  i2c_priority_arbiter #(
    .WIDTH (NEV)
  ) arbiter (
    .pending (pending),
    .code    (nextCode)
  );

  // ==========================================================================
  // FIFO level counters
  assign txClear = inReset || !state_reg.txFifoOn ||
                   (regWrite && regAddr == i2c_irq_pkg::OFF_TX_FIFO &&
                    regWrData[i2c_irq_pkg::FIFO_CLEAR_BIT]);
  assign rxClear = inReset || !state_reg.rxFifoOn ||
                   (regWrite && regAddr == i2c_irq_pkg::OFF_RX_FIFO &&
                    regWrData[i2c_irq_pkg::FIFO_CLEAR_BIT]);

  i2c_fifo_level_counter txCounter (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clear     (txClear),
    .byteDone  (txFifoByte),
    .threshold (state_reg.txThresh),
    .level     (txLevel),
    .reached   (txReached)
  );

  i2c_fifo_level_counter rxCounter (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clear     (rxClear),
    .byteDone  (rxFifoByte),
    .threshold (state_reg.rxThresh),
    .level     (rxLevel),
    .reached   (rxReached)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [NEV-1:0] clr;
    logic [NEV-1:0] setMask;
    clr        = '0;
    setMask    = '0;
    state_next = state_reg;

    // Pin inputs: three stages, change accepted when last two agree
    state_next.sdaSync = {state_reg.sdaSync[1:0], sdaIn};
    state_next.sclSync = {state_reg.sclSync[1:0], sclIn};
    if (state_reg.sdaSync[2] == state_reg.sdaSync[1])
    begin
      state_next.sdaLevel = state_reg.sdaSync[2];
    end
    if (state_reg.sclSync[2] == state_reg.sclSync[1])
    begin
      state_next.sclLevel = state_reg.sclSync[2];
    end

    // Register writes
    if (regWrite)
    begin
      case (regAddr)
        i2c_irq_pkg::OFF_OWN_ADDR: state_next.ownAddr  = regWrData;
        i2c_irq_pkg::OFF_ENABLE:   state_next.enable   = regWrData[NEV-1:0];
        i2c_irq_pkg::OFF_STATUS:   clr = regWrData[NEV-1:0];
        i2c_irq_pkg::OFF_CLK_LOW:  state_next.clkLow   = regWrData;
        i2c_irq_pkg::OFF_CLK_HIGH: state_next.clkHigh  = regWrData;
        i2c_irq_pkg::OFF_COUNT:    state_next.count    = regWrData;
        i2c_irq_pkg::OFF_TARGET:   state_next.target   = regWrData;
        i2c_irq_pkg::OFF_TX_DATA:
        begin
          state_next.txData  = regWrData;
          state_next.txEmpty = 1'b1;
        end
        i2c_irq_pkg::OFF_MODE:     state_next.mode     = regWrData;
        i2c_irq_pkg::OFF_EXT_MODE: state_next.extMode  = regWrData;
        i2c_irq_pkg::OFF_PRESCALE: state_next.prescale = regWrData;
        i2c_irq_pkg::OFF_TX_FIFO:
        begin
          state_next.txFifoOn = regWrData[i2c_irq_pkg::FIFO_ENABLE_BIT];
          state_next.txThresh = (regWrData[2:0] > i2c_irq_pkg::FIFO_MAX) ?
                                i2c_irq_pkg::FIFO_MAX : regWrData[2:0];
          if (regWrData[i2c_irq_pkg::FIFO_CLEAR_BIT])
          begin
            state_next.txFifoFlag = 1'b0;
          end
        end
        i2c_irq_pkg::OFF_RX_FIFO:
        begin
          state_next.rxFifoOn = regWrData[i2c_irq_pkg::FIFO_ENABLE_BIT];
          state_next.rxThresh = (regWrData[2:0] > i2c_irq_pkg::FIFO_MAX) ?
                                i2c_irq_pkg::FIFO_MAX : regWrData[2:0];
          if (regWrData[i2c_irq_pkg::FIFO_CLEAR_BIT])
          begin
            state_next.rxFifoFlag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Source read clears the reported flag, ready flags excepted
    if (regRead && regAddr == i2c_irq_pkg::OFF_SOURCE &&
        state_reg.source != 3'h0)
    begin
      clr[state_reg.source - 3'h1] = 1'b1;
      clr[i2c_irq_pkg::EV_ACC_READY] = clr[i2c_irq_pkg::EV_ACC_READY] &&
        !(regRead && state_reg.source == 3'(i2c_irq_pkg::EV_ACC_READY + 1));
      clr[i2c_irq_pkg::EV_RX_READY] = clr[i2c_irq_pkg::EV_RX_READY] &&
        !(regRead && state_reg.source == 3'(i2c_irq_pkg::EV_RX_READY + 1));
      clr[i2c_irq_pkg::EV_TX_READY] = clr[i2c_irq_pkg::EV_TX_READY] &&
        !(regRead && state_reg.source == 3'(i2c_irq_pkg::EV_TX_READY + 1));
    end

    // Set wins over clear
    state_next.flags = (state_reg.flags & ~clr) | events;
    if (txLoaded)
    begin
      state_next.txEmpty = 1'b0;
    end
    if (rxCopied)
    begin
      state_next.rxData = {8'h00, 8'h00};
    end
    // Counter still shows the old level during a clear; ignore it then
    state_next.txFifoFlag = state_next.txFifoFlag | (txReached && !txClear);
    state_next.rxFifoFlag = state_next.rxFifoFlag | (rxReached && !rxClear);

    // Arbiter reloads source with the lowest pending code
    state_next.source   = nextCode;
    state_next.basicIrq = (nextCode != 3'h0) && !inReset;
    state_next.fifoIrq  = (state_next.txFifoFlag || state_next.rxFifoFlag) &&
                          !inReset;

    // Module reset holds status at default
    if (inReset)
    begin
      state_next.flags      = i2c_irq_pkg::STATUS_RESET[NEV-1:0];
      state_next.txEmpty    = i2c_irq_pkg::STATUS_RESET[
                                i2c_irq_pkg::STATUS_TX_EMPTY];
      state_next.txFifoFlag = 1'b0;
      state_next.rxFifoFlag = 1'b0;
      state_next.source     = 3'h0;
    end
    state_next.enabledOut = !inReset;

    // Read data, one cycle later; reserved offsets read zero
    state_next.rdData = 16'h0000;
    if (regRead)
    begin
      case (regAddr)
        i2c_irq_pkg::OFF_OWN_ADDR: state_next.rdData = state_reg.ownAddr;
        i2c_irq_pkg::OFF_ENABLE:   state_next.rdData = 16'(state_reg.enable);
        i2c_irq_pkg::OFF_STATUS:
        begin
          state_next.rdData = 16'(state_reg.flags);
          state_next.rdData[i2c_irq_pkg::STATUS_TX_EMPTY] = state_reg.txEmpty;
        end
        i2c_irq_pkg::OFF_CLK_LOW:  state_next.rdData = state_reg.clkLow;
        i2c_irq_pkg::OFF_CLK_HIGH: state_next.rdData = state_reg.clkHigh;
        i2c_irq_pkg::OFF_COUNT:    state_next.rdData = state_reg.count;
        i2c_irq_pkg::OFF_RX_DATA:  state_next.rdData = state_reg.rxData;
        i2c_irq_pkg::OFF_TARGET:   state_next.rdData = state_reg.target;
        i2c_irq_pkg::OFF_TX_DATA:  state_next.rdData = state_reg.txData;
        i2c_irq_pkg::OFF_MODE:     state_next.rdData = state_reg.mode;
        i2c_irq_pkg::OFF_SOURCE:   state_next.rdData = 16'(state_reg.source);
        i2c_irq_pkg::OFF_EXT_MODE: state_next.rdData = state_reg.extMode;
        i2c_irq_pkg::OFF_PRESCALE: state_next.rdData = state_reg.prescale;
        i2c_irq_pkg::OFF_TX_FIFO:
          state_next.rdData = {8'h00, state_reg.txFifoFlag, 1'b0,
                               state_reg.txFifoOn, 2'b00, state_reg.txThresh}
                              | {5'h00, txLevel, 8'h00};
        i2c_irq_pkg::OFF_RX_FIFO:
          state_next.rdData = {8'h00, state_reg.rxFifoFlag, 1'b0,
                               state_reg.rxFifoOn, 2'b00, state_reg.rxThresh}
                              | {5'h00, rxLevel, 8'h00};
        default: state_next.rdData = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // State register; device reset leaves the module held in reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg         <= '0;
      state_reg.flags   <= i2c_irq_pkg::STATUS_RESET[NEV-1:0];
      state_reg.txEmpty <= 1'b1;
      state_reg.sdaSync <= 3'b111;
      state_reg.sclSync <= 3'b111;
      state_reg.sdaLevel <= 1'b1;
      state_reg.sclLevel <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs registered, pin controls tied to constants; pins only released here, framing lives elsewhere
  assign regRdData           = state_reg.rdData;
  assign basicEventInterrupt = state_reg.basicIrq;
  assign fifoLevelInterrupt  = state_reg.fifoIrq;
  assign moduleEnabled       = state_reg.enabledOut;
  assign sdaOut              = 1'b0;
  assign sdaOe               = 1'b0;
  assign sclOut              = 1'b0;
  assign sclOe               = 1'b0;

endmodule : i2c_interrupt_reset
`default_nettype wire

// file: i2c_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [8:0] fireReq,
  output logic      [8:0] pulses,
  output logic            sdaLine,
  output logic            sclLine
);
  // ==========================================================
  // Bus events
  // Registered, so each request appears one cycle later and lasts as long as it was held
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulses <= 9'h000;
    else
      pulses <= fireReq;
  end

  // ==========================================================
  // Lines
  // Block never drives the pins, so the pull-ups win
  assign sdaLine = 1'b1;
  assign sclLine = 1'b1;
endmodule : i2c_bus_partner
`default_nettype wire

// file: i2c_interrupt_reset_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_reset_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  input wire logic        arbLost,
  input wire logic        txFifoByte,
  input wire logic        rxFifoByte,
  input wire logic        sdaOe,
  input wire logic        sclOe,
  input wire logic        moduleEnabled,
  input wire logic        basicEventInterrupt,
  input wire logic        fifoLevelInterrupt
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Shadow state
  logic [6:0] enReg;
  logic [2:0] sinceByte;
  logic       reservedHit;
  logic       srcRead;
  assign reservedHit = (regAddr > 6'h0C && regAddr < 6'h20) || regAddr > 6'h21;
  assign srcRead = regRead && regAddr == i2c_irq_pkg::OFF_SOURCE;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      enReg <= 7'h00;
    else if (regWrite && regAddr == i2c_irq_pkg::OFF_ENABLE)
      enReg <= regWrData[6:0];
  end
  // Saturates, so a long idle never wraps into a false recent byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sinceByte <= 3'h7;
    else if (txFifoByte || rxFifoByte)
      sinceByte <= 3'h0;
    else if (sinceByte != 3'h7)
      sinceByte <= sinceByte + 3'h1;
  end

  // ==========================================================
  // Properties
  a_pins_released: assert property (!sdaOe && !sclOe)
    else $error("pin enable raised");
  a_enable_follow: assert property (
    regWrite && regAddr == i2c_irq_pkg::OFF_MODE |-> ##2
    moduleEnabled == $past(regWrData[i2c_irq_pkg::MODE_RESET_BIT], 2))
    else $error("module enable not following reset bit");
  a_reserved_zero: assert property (
    regRead && reservedHit |=> regRdData == 16'h0000)
    else $error("reserved offset read nonzero");
  a_event_raise: assert property (
    arbLost && enReg[0] && moduleEnabled |-> ##2 basicEventInterrupt)
    else $error("enabled event gave no request");
  a_masked_quiet: assert property (
    enReg == 7'h00 && $past(enReg) == 7'h00 && $past(enReg, 2) == 7'h00
    |-> !basicEventInterrupt)
    else $error("request with all enables off");
  a_reset_quiet: assert property (
    !moduleEnabled && !$past(moduleEnabled)
    |-> !basicEventInterrupt && !fifoLevelInterrupt)
    else $error("request while module held in reset");
  a_top_code: assert property (
    arbLost && enReg[0] && moduleEnabled ##[3:4] srcRead
    |=> regRdData == 16'h0001)
    else $error("arbitration lost not reported first");
  a_fifo_byte: assert property (
    $rose(fifoLevelInterrupt) |-> sinceByte < 3'h6)
    else $error("fifo request without a byte");

  c_irq_drop: cover property (basicEventInterrupt ##1 !basicEventInterrupt);
  c_fifo_irq: cover property (fifoLevelInterrupt);
  c_src_read: cover property (srcRead ##1 regRdData != 16'h0000);
endmodule : i2c_interrupt_reset_checker

bind i2c_interrupt_reset i2c_interrupt_reset_checker checker_inst (
  .core_clk,
  .rst_n,
  .regAddr,
  .regWrData,
  .regWrite,
  .regRead,
  .regRdData,
  .arbLost,
  .txFifoByte,
  .rxFifoByte,
  .sdaOe,
  .sclOe,
  .moduleEnabled,
  .basicEventInterrupt,
  .fifoLevelInterrupt
);
`default_nettype wire

// file: i2c_interrupt_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_reset_tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdData;
  logic [8:0]  fireReq = 9'h000;
  logic [8:0]  pulses;
  logic        sdaLine;
  logic        sclLine;
  logic        sdaOe;
  logic        sclOe;
  logic        moduleEnabled;
  logic        basicIrq;
  logic        fifoIrq;
  logic [31:0] seed = 32'h0000_bc6c;
  int          bad_count = 0;
  int          checked = 0;

  always #10 core_clk = ~core_clk;

  i2c_bus_partner partner (.core_clk(core_clk), .rst_n(rst_n),
    .fireReq(fireReq), .pulses(pulses), .sdaLine(sdaLine),
    .sclLine(sclLine));

  i2c_interrupt_reset DUT (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .txLoaded(pulses[4]),
    .rxCopied(pulses[3]), .accessDone(pulses[2]), .noAck(pulses[1]),
    .arbLost(pulses[0]), .stopSeen(pulses[5]), .addressed(pulses[6]),
    .txFifoByte(pulses[7]), .rxFifoByte(pulses[8]), .sdaIn(sdaLine),
    .sclIn(sclLine), .sdaOut(), .sdaOe(sdaOe), .sclOut(),
    .sclOe(sclOe), .moduleEnabled(moduleEnabled),
    .basicEventInterrupt(basicIrq), .fifoLevelInterrupt(fifoIrq));

  // ==========================================================
  // Expectations and stimulus helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Lowest event bit wins
  function automatic logic [15:0] topCode(input logic [6:0] m);
    topCode = 16'h0000;
    for (int i = 6; i >= 0; i--)
      if (m[i])
        topCode = 16'(i + 1);
  endfunction : topCode

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic rdChk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdChk

  // Event lands two edges on; two more let flag and arbiter settle
  task automatic fire(input logic [8:0] m);
    @(posedge core_clk);
    fireReq <= m;
    @(posedge core_clk);
    fireReq <= 9'h000;
    repeat (2) @(posedge core_clk);
  endtask : fire

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [15:0] d;
    logic [6:0]  m;
    logic [2:0]  n;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 36; a++)
      rdChk(6'(a), a == 2 ? i2c_irq_pkg::STATUS_RESET : 16'h0000);
    chk(moduleEnabled, 1'b0);
    wr(6'h0D, 16'hffff);
    rdChk(6'h0D, 16'h0000);
    m = seed[6:0];
    wr(i2c_irq_pkg::OFF_ENABLE, {9'h000, m});
    rdChk(i2c_irq_pkg::OFF_ENABLE, {9'h000, m});
    wr(i2c_irq_pkg::OFF_ENABLE, 16'h007F);
    wr(i2c_irq_pkg::OFF_MODE, 16'h0020);
    fire(9'h07F);
    chk(moduleEnabled, 1'b1);
    // All seven pending: walk the priority order
    for (int k = 1; k <= 7; k++)
    begin
      rdChk(i2c_irq_pkg::OFF_SOURCE, 16'(k));
      chk(basicIrq, 1'b1);
      if (k >= 3 && k <= 5)
      begin
        rdChk(i2c_irq_pkg::OFF_SOURCE, 16'(k));
        wr(i2c_irq_pkg::OFF_STATUS, 16'(1 << (k - 1)));
      end
      repeat (2) @(posedge core_clk);
    end
    rdChk(i2c_irq_pkg::OFF_SOURCE, 16'h0000);
    chk(basicIrq, 1'b0);
    wr(i2c_irq_pkg::OFF_ENABLE, 16'h0000);
    repeat (8)
    begin
      seed = lfsr(seed);
      m = (seed[6:0] == 7'h00) ? 7'h40 : seed[6:0];
      fire({2'b00, m});
      chk(basicIrq, 1'b0);
      rd(i2c_irq_pkg::OFF_STATUS, d);
      chk(d & 16'h007F, {9'h000, m});
      wr(i2c_irq_pkg::OFF_ENABLE, {9'h000, m});
      rdChk(i2c_irq_pkg::OFF_SOURCE, topCode(m));
      chk(basicIrq, 1'b1);
      wr(i2c_irq_pkg::OFF_STATUS, 16'h007F);
      wr(i2c_irq_pkg::OFF_ENABLE, 16'h0000);
      repeat (3) @(posedge core_clk);
      chk(basicIrq, 1'b0);
    end
    // Ready enables stay off while the fifos are in use
    for (int f = 0; f < 2; f++)
    begin
      seed = lfsr(seed);
      n = (f == 1) ? 3'h4 : 3'(seed[1:0]) + 3'h1;
      wr(6'(32 + f), 16'h0020 | 16'(n));
      repeat (n - 1) fire((f == 1) ? 9'h100 : 9'h080);
      chk(fifoIrq, 1'b0);
      fire((f == 1) ? 9'h100 : 9'h080);
      repeat (2) @(posedge core_clk);
      chk(fifoIrq, 1'b1);
      rd(6'(32 + f), d);
      chk(d[7], 1'b1);
      rd(6'(33 - f), d);
      chk(d[7], 1'b0);
      wr(6'(32 + f), 16'h0060 | 16'(n));
      repeat (3) @(posedge core_clk);
      chk(fifoIrq, 1'b0);
    end
    fire(9'h07F);
    wr(i2c_irq_pkg::OFF_MODE, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(moduleEnabled, 1'b0);
    rdChk(i2c_irq_pkg::OFF_STATUS, i2c_irq_pkg::STATUS_RESET);
    fire(9'h07F);
    rdChk(i2c_irq_pkg::OFF_STATUS, i2c_irq_pkg::STATUS_RESET);
    // Device reset in mid-run wipes what software wrote
    wr(i2c_irq_pkg::OFF_ENABLE, 16'h007F);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(i2c_irq_pkg::OFF_ENABLE, 16'h0000);
    rdChk(i2c_irq_pkg::OFF_STATUS, i2c_irq_pkg::STATUS_RESET);
    chk(moduleEnabled, 1'b0);
    end_sim();
  end
endmodule : i2c_interrupt_reset_tb
`default_nettype wire
